// >>> bench/conv_sync_path_props.sv
// concurrent checks on the converter sync path ports
`timescale 1ns/1ps
module conv_sync_path_props (
   input wire mclk_i,
   input wire reset_i,
   input wire sync_trigger_i,
   input wire processed_valid_o,
   input wire processed_odd_o,
   input wire sample_even_o,
   input wire [3:0] pattern_phase_o,
   input wire data_settling_o,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hsel,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata
);
   // ****
   // helpers
   // ****
   reg rd_q;
   reg ofs_q;
   always @(posedge mclk_i)
   begin
      rd_q <= hsel && hready && htrans[1] && !hwrite && !reset_i;
      ofs_q <= haddr[11:7] == 5'h02;
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);
   sequence s_settle_run;
      data_settling_o [*4];
   endsequence
   sequence s_pin_seen;
      $past(sync_trigger_i, 2) || $past(sync_trigger_i, 3) || $past(sync_trigger_i, 4);
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready okay");
   a_read_idle_zero: assert property (!rd_q |-> hrdata == 32'h0000_0000)
      else $error("read data outside data phase");
   a_offset_width: assert property (rd_q && ofs_q |-> hrdata[31:10] == 22'h00_0000)
      else $error("offset read wider than ten bits");
   a_odd_follows: assert property (!$past(reset_i) |-> processed_odd_o == !$past(sample_even_o))
      else $error("stream tag not following sample phase");
   a_valid_gap: assert property (!processed_valid_o && $past(processed_valid_o) |=> processed_valid_o)
      else $error("conversion tick missing");
   a_settle_cause: assert property ($rose(data_settling_o) |-> s_pin_seen)
      else $error("settling without trigger edge");
   a_settle_hold: assert property ($rose(data_settling_o) |-> s_settle_run)
      else $error("settling window too short");
   a_settle_end: assert property (data_settling_o |-> ##[1:8] !data_settling_o)
      else $error("settling window too long");
   a_phase_reset: assert property ($rose(data_settling_o) |-> pattern_phase_o < 4'h2)
      else $error("pattern phase not reset");
endmodule // conv_sync_path_props
bind conv_sync_path conv_sync_path_props i_conv_sync_path_props (.mclk_i, .reset_i,
   .sync_trigger_i, .processed_valid_o, .processed_odd_o, .sample_even_o, .pattern_phase_o,
   .data_settling_o, .haddr, .htrans, .hwrite, .hsel, .hready, .hreadyout, .hresp, .hrdata);

// >>> bench/testbench.sv
// self-checking bench for the converter sync path
`timescale 1ns/1ps
`include "conv_path_consts.vh"
module testbench;
   reg mclk_i = 1'b0;
   reg reset_i = 1'b1;
   reg fire_q = 1'b0;
   reg [1:0] len_q = 2'h1;
   reg [223:0] conv_q = 224'h0;
   reg [159:0] auto_q = 160'h0;
   reg [31:0] haddr = 32'h0000_0000;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h0000_0000;
   reg hsel = 1'b0;
   reg [31:0] rdata;
   reg [31:0] seed = 32'h0001_2764;
   reg [9:0] ofs [0:31];
   reg [9:0] ov;
   reg ev;
   wire rdy;
   wire trig;
   wire [255:0] word;
   wire valid;
   wire odd;
   wire even;
   wire settle;
   wire [31:0] hrdata;
   integer errors = 0;
   integer checks = 0;
   integer i;
   integer g;
   integer m;
   integer n;
   integer seen;
   always #25 mclk_i = ~mclk_i;
   trig_host i_trig_host (.mclk_i(mclk_i), .fire_i(fire_q), .len_i(len_q), .sync_trigger_o(trig));
   conv_sync_path i_conv_sync_path (.mclk_i(mclk_i), .reset_i(reset_i), .sync_trigger_i(trig),
      .converter_result_word_i(conv_q), .auto_offset_i(auto_q), .processed_word_o(word),
      .processed_valid_o(valid), .processed_odd_o(odd), .conv_clk_o(), .sample_even_o(even),
      .frame_phase_o(), .pattern_phase_o(), .data_settling_o(settle), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel),
      .hready(rdy), .hreadyout(rdy), .hresp(), .hrdata(hrdata));
   // ****
   // helpers
   // ****
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
   begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
   end
   endfunction
   function [15:0] just(input [13:0] r, input [1:0] res);
   begin
      just = {r, 2'h0} & (res == 2'h0 ? 16'hFFC0 : res == 2'h1 ? 16'hFFF0 : 16'hFFFC);
   end
   endfunction
   task check(input [31:0] seen_v, input [31:0] exp_v);
   begin
      checks = checks + 1;
      if (seen_v !== exp_v)
      begin
         errors = errors + 1;
         $display("mismatch at %0t seen %h expected %h", $time, seen_v, exp_v);
      end
   end
   endtask
   task finish_test;
   begin
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   task bus(input w, input [11:0] a, input [31:0] d);
   begin
      haddr <= {20'h0_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsel <= 1'b1;
      @(posedge mclk_i);
      while (rdy !== 1'b1)
         @(posedge mclk_i);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge mclk_i);
      while (rdy !== 1'b1)
         @(posedge mclk_i);
      rdata = hrdata;
   end
   endtask
   task fire;
   begin
      fire_q <= 1'b1;
      @(posedge mclk_i);
      fire_q <= 1'b0;
      seen = 0;
      repeat (16)
      begin
         @(posedge mclk_i);
         seen = seen + settle;
      end
   end
   endtask
   // ****
   // main sequence
   // ****
   initial
   begin
      repeat (6) @(posedge mclk_i);
      reset_i <= 1'b0;
      fire;
      check(seen, `SETTLE_CLKS);
      bus(0, 12'h000, 32'h0000_0000);
      check(rdata, 32'h0000_0000);
      for (i = 0; i < 32; i = i + 1)
      begin
         seed = xs(seed);
         ofs[i] = {{5{seed[4]}}, seed[4:0]};
         bus(1, 12'h100 + {i[9:0], 2'h0}, {seed[31:10], ofs[i]});
      end
      bus(1, 12'h180, seed);
      for (i = 0; i < 33; i = i + 1)
      begin
         bus(0, 12'h100 + {i[9:0], 2'h0}, 32'h0000_0000);
         check(rdata, i < 32 ? {22'h00_0000, ofs[i]} : 32'h0000_0000);
      end
      for (m = 0; m < 3; m = m + 1)
      begin
         bus(1, 12'h000, {24'h00_0000, 4'h6, m[1:0], 2'h0});
         repeat (4)
         begin
            seed = xs(seed);
            conv_q <= {7{seed}};
            repeat (2) @(posedge mclk_i);
            for (g = 0; g < 16; g = g + 1)
               check(word[g*16 +: 16], just(conv_q[g*14 +: 14], m[1:0]));
         end
      end
      for (m = 0; m < 3; m = m + 1)
      begin
         bus(1, 12'h000, {26'h000_000A, m[1:0]});
         seed = xs(seed);
         len_q <= seed[1:0] | 2'h1;
         fire;
         n = 0;
         for (i = 0; i < 8; i = i + 1)
         begin
            @(posedge mclk_i);
            n = n + valid;
            if (i > 0 && m != 2)
               check(even, !ev);
            ev = even;
         end
         check(n, m == 2 ? 4 : 8);
         check(word[15:0], just(conv_q[13:0], m == 2 ? 2'h0 : 2'h2));
      end
      bus(1, 12'h000, 32'h0000_0010);
      fire;
      check(seen, 0);
      for (m = 0; m < 2; m = m + 1)
      begin
         bus(1, 12'h000, {24'h00_0000, m[0], 7'h40});
         for (g = 0; g < 16; g = g + 1)
         begin
            seed = xs(seed);
            conv_q[g*14 +: 14] <= {seed[7:0], 6'h00} + 14'h0400;
            auto_q[g*10 +: 10] <= {{5{seed[12]}}, seed[12:8]};
         end
         repeat (40) @(posedge mclk_i);
         repeat (2)
         begin
            @(posedge mclk_i);
            for (g = 0; g < 16; g = g + 1)
            begin
               ov = m ? auto_q[g*10 +: 10] : ofs[2 * g + (odd ? 0 : 1)];
               check(word[g*16 +: 16], {conv_q[g*14+4 +: 10] - ov, 6'h00});
            end
         end
      end
      finish_test;
   end
   initial
   begin
      repeat (6000) @(posedge mclk_i);
      errors = errors + 1;
      finish_test;
   end
endmodule // testbench

// >>> bench/trig_host.sv
// host side trigger source with selectable pulse length
`timescale 1ns/1ps
module trig_host (
   input wire mclk_i,
   input wire fire_i,
   input wire [1:0] len_i,
   output reg sync_trigger_o
);
   reg [1:0] cnt_q = 2'h0;
   initial sync_trigger_o = 1'b0;
   always @(posedge mclk_i)
   begin
      if (fire_i)
         cnt_q <= len_i;
      else if (cnt_q != 2'h0)
         cnt_q <= cnt_q - 2'h1;
      sync_trigger_o <= fire_i || cnt_q > 2'h1;
   end
endmodule // trig_host

// >>> design/conv_path_consts.vh
// constants for the converter sync and offset path
`ifndef CONV_PATH_CONSTS_VH
`define CONV_PATH_CONSTS_VH
// register byte addresses
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_OFS_BASE 12'h100
`define REG_OFS_LAST 12'h17C
`define REG_ID 12'h008
// control field positions
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_RES_LO 2
`define CTRL_RES_HI 3
`define CTRL_MASK 4
`define CTRL_LOWLAT 5
`define CTRL_OFS_EN 6
`define CTRL_AUTO_SEL 7
`define CTRL_WIDTH 8
`define CTRL_RESET 8'h00
// input modes
`define MODE_16 2'h0
`define MODE_32 2'h1
`define MODE_8 2'h2
// resolution codes
`define RES_10 2'h0
`define RES_12 2'h1
`define RES_14 2'h2
// data widths
`define OFS_W 10
`define RAW_W 14
`define OUT_W 16
`define NUM_CONV 16
`define OFS_DEPTH 32
`define OFS_AW 5
// settle window after a trigger, in system clocks
`define SETTLE_CLKS 4'h6
`define SETTLE_LOAD 3'h5
// ahb codes
`define HTRANS_NONSEQ 2'b10
`define HTRANS_SEQ 2'b11
`endif

// >>> design/conv_sync_path.v
// sync, sample phasing and offset path of a sixteen converter array
// Function
// RQ1: sixteen lockstep converters, signed twos complement results
// RQ2: conversion clock derived internally, one result each
// RQ3: odd/even sample mapping follows input mode
// RQ4: result width selectable 10, 12, 14
// RQ5: controller keeps conversion rate under resolution limit
// RQ6: 16/32 modes conversion equals system clock
// RQ7: 8-input mode divides by two, 10-bit only
// RQ8: 32-input mode alternates, trigger fixes odd phase
// RQ9: trigger synchronizes all internal dividers
// RQ10: controller applies trigger at initialization
// RQ11: trigger resets pattern, sample and frame phases
// RQ12: receiver distrusts data four to six clocks
// RQ13: mask control ignores trigger for phase reset
// RQ14: untriggered frame phase free running, framing undefined
// RQ15: untriggered test pattern phase unaligned
// RQ16: processed word sixteen bits, result left justified
// RQ17: low latency routes results around processing
// RQ18: offset enable subtracts selected offset
// RQ19: offset source manual or automatic by mode
// RQ20: manual offset ten bit twos complement register
// RQ21: thirty-two manual offsets, odd and even streams
// RQ22: two sampling circuits converted in alternation
// RQ23: even inputs sampled one clock after odd
// RQ24: trigger sampled synchronously, rising edge is event
`timescale 1ns/1ps
`include "conv_path_consts.vh"
module conv_sync_path #(
   parameter NUM_CONV = `NUM_CONV,
   parameter RAW_W = `RAW_W,
   parameter OUT_W = `OUT_W,
   parameter OFS_W = `OFS_W,
   parameter [31:0] ID_VALUE = 32'h0000_5A5A
) (
   input wire mclk_i,
   input wire reset_i,
   input wire sync_trigger_i,
   input wire [NUM_CONV*RAW_W-1:0] converter_result_word_i,
   input wire [NUM_CONV*OFS_W-1:0] auto_offset_i,
   output reg [NUM_CONV*OUT_W-1:0] processed_word_o,
   output reg processed_valid_o,
   output reg processed_odd_o,
   output wire conv_clk_o,
   output reg sample_even_o,
   output reg frame_phase_o,
   output reg [3:0] pattern_phase_o,
   output reg data_settling_o,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hsel,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata
);
   // ************************************************************
   // control register and ahb slave
   // ************************************************************
   reg [`CTRL_WIDTH-1:0] ctrl_q;
   reg wr_pend_q;
   reg rd_pend_q;
   reg [11:0] addr_q;
   reg [3:0] trig_count_q;
   reg conv_clk_q;
   wire [OFS_W-1:0] bus_ofs;
   wire take = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
   wire [1:0] mode = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
   wire [1:0] res = ctrl_q[`CTRL_RES_HI:`CTRL_RES_LO];
   wire ofs_hit = (addr_q >= `REG_OFS_BASE) && (addr_q <= `REG_OFS_LAST);
   wire ofs_wr = wr_pend_q && ofs_hit;
   wire [4:0] ofs_waddr = addr_q[6:2];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 12'h000;
         ctrl_q <= `CTRL_RESET;
      end
      else
      begin
         wr_pend_q <= take && hwrite;
         rd_pend_q <= take && !hwrite;
         if (take)
         begin
            addr_q <= haddr[11:0];
         end
         if (wr_pend_q && addr_q == `REG_CTRL)
         begin
            ctrl_q <= hwdata[`CTRL_WIDTH-1:0];
         end
      end
   end
   // read data: address phase registered, data formed combinationally from flops
   always @*
   begin
      hrdata = 32'h0000_0000;
      if (rd_pend_q)
      begin
         if (addr_q == `REG_CTRL)
         begin
            hrdata = {24'h00_0000, ctrl_q};
         end
         else if (addr_q == `REG_STATUS)
         begin
            hrdata = {20'h0_0000, trig_count_q, pattern_phase_o, data_settling_o,
               frame_phase_o, sample_even_o, conv_clk_q};
         end
         else if (addr_q == `REG_ID)
         begin
            hrdata = ID_VALUE;
         end
         else if (ofs_hit)
         begin
            hrdata = {{(32-OFS_W){1'b0}}, bus_ofs}; // [RQ20]
         end
      end
   end

   // ************************************************************
   // trigger capture and phase generation
   // ************************************************************
   reg trig_s1_q;
   reg trig_s2_q;
   reg trig_s3_q;
   reg [2:0] settle_q;
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         trig_s1_q <= 1'b0;
         trig_s2_q <= 1'b0;
         trig_s3_q <= 1'b0;
      end
      else
      begin
         trig_s1_q <= sync_trigger_i; // [RQ24]
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
      end
   end
   wire trig_edge = trig_s2_q && !trig_s3_q; // [RQ24]
   wire phase_reset = trig_edge && !ctrl_q[`CTRL_MASK]; // [RQ13]
   wire is8 = (mode == `MODE_8);
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         conv_clk_q <= 1'b0;
         sample_even_o <= 1'b0;
         frame_phase_o <= 1'b0;
         pattern_phase_o <= 4'h0;
         settle_q <= 3'h0;
         data_settling_o <= 1'b0;
         trig_count_q <= 4'h0;
      end
      else if (phase_reset)
      begin
         // all dividers restart together [RQ9] [RQ11]
         conv_clk_q <= is8; // [RQ7]
         sample_even_o <= 1'b0; // [RQ8]
         frame_phase_o <= 1'b0;
         pattern_phase_o <= 4'h0;
         settle_q <= `SETTLE_LOAD;
         data_settling_o <= 1'b1;
         trig_count_q <= trig_count_q + 4'h1;
      end
      else
      begin
         // free running when untriggered [RQ14] [RQ15]
         conv_clk_q <= is8 ? !conv_clk_q : 1'b0; // [RQ6]
         if (!is8 || conv_clk_q)
         begin
            sample_even_o <= !sample_even_o; // [RQ22] [RQ23]
            frame_phase_o <= (mode == `MODE_16) ? 1'b0 : !frame_phase_o;
         end
         pattern_phase_o <= pattern_phase_o + 4'h1;
         if (settle_q != 3'h0)
         begin
            settle_q <= settle_q - 3'h1;
         end
         data_settling_o <= (settle_q != 3'h0);
      end
   end
   // system clock passes straight through outside 8-input mode [RQ2]
   assign conv_clk_o = is8 ? conv_clk_q : mclk_i;
   wire conv_tick = !is8 || conv_clk_q; // [RQ2]

   // ************************************************************
   // manual offset storage
   // ************************************************************
   reg [4:0] scan_q;
   wire [OFS_W-1:0] scan_ofs;
   offset_ram #(
      .DW(OFS_W),
      .AW(`OFS_AW),
      .DEPTH(`OFS_DEPTH)
   ) u_ofs (
      .mclk_i(mclk_i),
      .wr_en_i(ofs_wr), // [RQ21]
      .wr_addr_i(ofs_waddr),
      .wr_data_i(hwdata[OFS_W-1:0]),
      .rd_addr_i(scan_q),
      .rd_data_o(scan_ofs),
      .bus_addr_i(take ? haddr[6:2] : addr_q[6:2]),
      .bus_data_o(bus_ofs)
   );
   // scan address delayed to match memory read data
   reg [4:0] scan_d1_q;
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         scan_q <= 5'h00;
         scan_d1_q <= 5'h00;
      end
      else
      begin
         scan_q <= scan_q + 5'h01;
         scan_d1_q <= scan_q;
      end
   end

   // ************************************************************
   // per converter processing
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < NUM_CONV; g = g + 1)
      begin : conv
         // stream 2g is odd, 2g+1 even [RQ21]
         reg [OFS_W-1:0] ofs_odd_q;
         reg [OFS_W-1:0] ofs_even_q;
         always @(posedge mclk_i)
         begin
            if (reset_i)
            begin
               ofs_odd_q <= {OFS_W{1'b0}};
               ofs_even_q <= {OFS_W{1'b0}};
            end
            else if (scan_d1_q[4:1] == g)
            begin
               if (scan_d1_q[0])
               begin
                  ofs_even_q <= scan_ofs;
               end
               else
               begin
                  ofs_odd_q <= scan_ofs;
               end
            end
         end
         reg [RAW_W-1:0] raw;
         reg [OUT_W-1:0] just;
         reg [OUT_W-1:0] ofs_w;
         reg [OFS_W-1:0] sel_ofs;
         always @*
         begin
            raw = converter_result_word_i[g*RAW_W +: RAW_W]; // [RQ1]
            // left justify by resolution [RQ4] [RQ16]
            case (is8 ? `RES_10 : res) // [RQ7]
               `RES_12: just = {raw[RAW_W-1:2], 4'h0};
               `RES_14: just = {raw, 2'h0};
               default: just = {raw[RAW_W-1:4], 6'h00};
            endcase
            sel_ofs = ctrl_q[`CTRL_AUTO_SEL] ? auto_offset_i[g*OFS_W +: OFS_W]
               : (sample_even_o ? ofs_even_q : ofs_odd_q); // [RQ19] [RQ3]
            // offset in units of the result lsb at the chosen width
            case (is8 ? `RES_10 : res)
               `RES_12: ofs_w = {{2{sel_ofs[OFS_W-1]}}, sel_ofs, 4'h0};
               `RES_14: ofs_w = {{4{sel_ofs[OFS_W-1]}}, sel_ofs, 2'h0};
               default: ofs_w = {sel_ofs, 6'h00};
            endcase
         end
         always @(posedge mclk_i)
         begin
            if (reset_i)
            begin
               processed_word_o[g*OUT_W +: OUT_W] <= {OUT_W{1'b0}};
            end
            else if (conv_tick)
            begin
               if (ctrl_q[`CTRL_LOWLAT] || !ctrl_q[`CTRL_OFS_EN])
               begin
                  processed_word_o[g*OUT_W +: OUT_W] <= just; // [RQ17] [RQ16]
               end
               else
               begin
                  processed_word_o[g*OUT_W +: OUT_W] <= just - ofs_w; // [RQ18]
               end
            end
         end
      end
   endgenerate
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         processed_valid_o <= 1'b0;
         processed_odd_o <= 1'b0;
      end
      else
      begin
         processed_valid_o <= conv_tick;
         processed_odd_o <= !sample_even_o; // [RQ22]
      end
   end
endmodule // conv_sync_path

// >>> design/offset_ram.v
// memory with one write and two read ports holding the manual per-stream offsets
`timescale 1ns/1ps
module offset_ram #(
   parameter DW = 10,
   parameter AW = 5,
   parameter DEPTH = 32
) (
   input wire mclk_i,
   input wire wr_en_i,
   input wire [AW-1:0] wr_addr_i,
   input wire [DW-1:0] wr_data_i,
   input wire [AW-1:0] rd_addr_i,
   output reg [DW-1:0] rd_data_o,
   input wire [AW-1:0] bus_addr_i,
   output reg [DW-1:0] bus_data_o
);
   reg [DW-1:0] mem [0:DEPTH-1];
   always @(posedge mclk_i)
   begin
      if (wr_en_i)
      begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
      bus_data_o <= mem[bus_addr_i];
   end
endmodule // offset_ram
